// file: inc/rcc_pkg.sv
// constants and types for the clock output control block
package rcc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] RCC_REG_INT_CTRL = 8'h10;
  localparam logic [7:0] RCC_REG_INT_MASK = 8'h12;
  localparam logic [7:0] RCC_REG_OUT_CFG = 8'h35;
  localparam logic [7:0] RCC_INT_CTRL_RST = 8'h00;
  localparam logic [7:0] RCC_INT_MASK_RST = 8'h00;
  localparam logic [7:0] RCC_OUT_CFG_RST = 8'h80;
  localparam logic [7:0] RCC_RD_UNMAPPED = 8'h00;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int RCC_IGOE_BIT = 0;
  localparam int RCC_CLOCK_INTERRUPT_FLAG_BIT = 7;
  localparam int RCC_FD_LSB = 0;
  localparam int RCC_FD_MSB = 2;
  localparam int RCC_SYNC_BIT = 6;
  localparam int RCC_NOE_BIT = 7;
  localparam int RCC_NUM_IRQ = 6;
  // ----------------------------------------------------------------
  // frequency codes and divider taps (divider runs at twice 32.768 khz)
  // ----------------------------------------------------------------
  localparam logic [2:0] RCC_FD_32K = 3'h0;
  localparam logic [2:0] RCC_FD_8K = 3'h1;
  localparam logic [2:0] RCC_FD_1K = 3'h2;
  localparam logic [2:0] RCC_FD_64 = 3'h3;
  localparam logic [2:0] RCC_FD_32 = 3'h4;
  localparam logic [2:0] RCC_FD_1 = 3'h5;
  localparam logic [2:0] RCC_FD_TIMER = 3'h6;
  localparam logic [2:0] RCC_FD_OFF = 3'h7;
  localparam logic [3:0] RCC_TAP_32K = 4'h0;
  localparam logic [3:0] RCC_TAP_8K = 4'h2;
  localparam logic [3:0] RCC_TAP_1K = 4'h5;
  localparam logic [3:0] RCC_TAP_64 = 4'h9;
  localparam logic [3:0] RCC_TAP_32 = 4'ha;
  localparam logic [3:0] RCC_TAP_1 = 4'hf;
  // ----------------------------------------------------------------
  // serial bus framing
  // ----------------------------------------------------------------
  localparam logic [3:0] RCC_BIT_LAST = 4'h7;
  localparam logic [3:0] RCC_BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    RCC_ST_IDLE = 3'b000,
    RCC_ST_RX = 3'b001,
    RCC_ST_ACK = 3'b010,
    RCC_ST_TX = 3'b011,
    RCC_ST_RACK = 3'b100
  } rcc_bus_state_t;
  typedef enum logic [1:0] {
    RCC_PH_ADDR = 2'b00,
    RCC_PH_PTR = 2'b01,
    RCC_PH_DATA = 2'b10
  } rcc_phase_t;
endpackage : rcc_pkg

// file: hdl/rcc_clock_output.sv
// serial register access, interrupt pin and square wave clock output
// How it works
// - pointer steps by one after every written or read data byte
// - flag clear: normal enable 1 drives wave, 0 holds pin low
// - interrupt-gated output works with the normal enable at 0
// - gated enable set: any masked interrupt starts the wave
// - gated enable written 0: new interrupts no longer start the wave
// - clearing the clock interrupt flag stops gated output, pin low with normal enable 0
// - normal and gated sources may both be active on the pin
// - frequency field picks 32768/8192/1024/64/32/1 hz or timer signal
// - frequency code 111 holds the pin low whatever the enables
// - sync select 1 synchronises both switching on and off
// - sync select has no effect on the timer signal
// - on backup supply the clock output pin is low
// - interrupt pin keeps working on backup supply
// - on backup supply the serial clock is ignored
// - on backup supply the serial data pin is released
// - external event input stays live on backup supply
`timescale 1ns/10ps
`default_nettype none
module rcc_clock_output #(
  parameter logic [6:0] DEV_ADDR = 7'h2a // arbitrary bus address
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic osc2x_clk,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic int_out,
  output logic int_oe_n,
  output logic square_wave_output_pin,
  input wire logic battery_supply_state,
  input wire logic external_event_input,
  input wire logic timer_irq,
  input wire logic update_irq,
  input wire logic alarm_irq,
  input wire logic switchover_irq,
  input wire logic por_irq
);
  // ----------------------------------------------------------------
  // pin synchronisers (core domain)
  // ----------------------------------------------------------------
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic bat_m, bat_s, evt_m, evt_s;
  // bus lines idle high, so they reset high to avoid a false start
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
      {bat_m, bat_s, evt_m, evt_s} <= 4'h0;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_pin, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
      {bat_m, bat_s} <= {battery_supply_state, bat_m};
      {evt_m, evt_s} <= {external_event_input, evt_m};
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  rcc_pkg::rcc_bus_state_t st_reg, st_next;
  rcc_pkg::rcc_phase_t ph_reg, ph_next;
  logic [3:0] bc_reg, bc_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next, ackon_reg, ackon_next, nack_reg, nack_next;
  logic drv_reg, drv_next;
  logic [7:0] rd_data;

  wire [7:0] rx_byte = {sh_reg[6:0], sda_s};
  wire addr_hit = (rx_byte[7:1] == DEV_ADDR);
  wire byte_done = (st_reg == rcc_pkg::RCC_ST_RX) && scl_rise && (bc_reg == rcc_pkg::RCC_BIT_LAST);
  wire wr_stb = byte_done && (ph_reg == rcc_pkg::RCC_PH_DATA);
  wire ptr_stb = byte_done && (ph_reg == rcc_pkg::RCC_PH_PTR);
  wire rd_load = (st_next == rcc_pkg::RCC_ST_TX) && (st_reg != rcc_pkg::RCC_ST_TX);

  // byte engine; start, stop and backup override whatever state it is in
  always_comb begin
    st_next = st_reg;
    ph_next = ph_reg;
    bc_next = bc_reg;
    sh_next = sh_reg;
    rw_next = rw_reg;
    ackon_next = ackon_reg;
    nack_next = nack_reg;
    drv_next = drv_reg;
    case (st_reg)
      rcc_pkg::RCC_ST_IDLE: begin
        drv_next = 1'b0;
      end
      rcc_pkg::RCC_ST_RX: begin
        if (scl_rise) begin
          sh_next = rx_byte;
          bc_next = 4'(bc_reg + 4'h1);
          if (bc_reg == rcc_pkg::RCC_BIT_LAST) begin
            ackon_next = 1'b0;
            if (ph_reg == rcc_pkg::RCC_PH_ADDR) begin
              rw_next = rx_byte[0];
              ph_next = rx_byte[0] ? rcc_pkg::RCC_PH_DATA : rcc_pkg::RCC_PH_PTR;
              st_next = addr_hit ? rcc_pkg::RCC_ST_ACK : rcc_pkg::RCC_ST_IDLE;
            end else begin
              ph_next = rcc_pkg::RCC_PH_DATA;
              st_next = rcc_pkg::RCC_ST_ACK;
            end
          end
        end
      end
      rcc_pkg::RCC_ST_ACK: begin
        if (scl_fall) begin
          if (!ackon_reg) begin
            ackon_next = 1'b1;
            drv_next = 1'b1;
          end else begin
            drv_next = 1'b0;
            bc_next = 4'h0;
            if (rw_reg) begin
              st_next = rcc_pkg::RCC_ST_TX;
              sh_next = rd_data;
              drv_next = ~rd_data[7];
            end else begin
              st_next = rcc_pkg::RCC_ST_RX;
            end
          end
        end
      end
      rcc_pkg::RCC_ST_TX: begin
        if (scl_rise) begin
          bc_next = 4'(bc_reg + 4'h1);
        end else if (scl_fall) begin
          if (bc_reg == rcc_pkg::RCC_BITS_PER_BYTE) begin
            drv_next = 1'b0;
            st_next = rcc_pkg::RCC_ST_RACK;
          end else begin
            sh_next = {sh_reg[6:0], 1'b0};
            drv_next = ~sh_reg[6];
          end
        end
      end
      rcc_pkg::RCC_ST_RACK: begin
        if (scl_rise) begin
          nack_next = sda_s;
        end else if (scl_fall) begin
          if (nack_reg) begin
            st_next = rcc_pkg::RCC_ST_IDLE;
          end else begin
            st_next = rcc_pkg::RCC_ST_TX;
            bc_next = 4'h0;
            sh_next = rd_data;
            drv_next = ~rd_data[7];
          end
        end
      end
      default: begin
        st_next = rcc_pkg::RCC_ST_IDLE;
      end
    endcase
    if (start_det) begin
      st_next = rcc_pkg::RCC_ST_RX;
      ph_next = rcc_pkg::RCC_PH_ADDR;
      bc_next = 4'h0;
      drv_next = 1'b0;
    end else if (stop_det) begin
      st_next = rcc_pkg::RCC_ST_IDLE;
      drv_next = 1'b0;
    end
    if (bat_s) begin
      st_next = rcc_pkg::RCC_ST_IDLE;
      drv_next = 1'b0;
    end
  end

  // pointer steps after each data byte in either direction
  assign ptr_next = ptr_stb ? rx_byte : (wr_stb || rd_load) ? 8'(ptr_reg + 8'h1) : ptr_reg;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_reg <= rcc_pkg::RCC_ST_IDLE;
      ph_reg <= rcc_pkg::RCC_PH_ADDR;
      {bc_reg, sh_reg, ptr_reg} <= 20'h00000;
      {rw_reg, ackon_reg, nack_reg, drv_reg} <= 4'h0;
    end else begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      {bc_reg, sh_reg, ptr_reg} <= {bc_next, sh_next, ptr_next};
      {rw_reg, ackon_reg, nack_reg, drv_reg} <= {rw_next, ackon_next, nack_next, drv_next};
    end
  end

  // open drain: only ever pull low, release otherwise
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drv_reg;

  // ----------------------------------------------------------------
  // registers, interrupt pin and clock interrupt flag
  // ----------------------------------------------------------------
  logic igoe_reg, clock_interrupt_flag_reg, clock_interrupt_flag_next, int_drv_reg;
  logic [7:0] mask_reg, cfg_reg;
  logic [rcc_pkg::RCC_NUM_IRQ-1:0] irq_d;

  // event input is synchronised and stays live on backup supply
  wire [rcc_pkg::RCC_NUM_IRQ-1:0] irq_vec =
    {por_irq, switchover_irq, evt_s, alarm_irq, update_irq, timer_irq};
  wire [rcc_pkg::RCC_NUM_IRQ-1:0] irq_rise = irq_vec & ~irq_d;
  wire wr_ctl = wr_stb && (ptr_reg == rcc_pkg::RCC_REG_INT_CTRL);
  wire wr_mask = wr_stb && (ptr_reg == rcc_pkg::RCC_REG_INT_MASK);
  wire wr_cfg = wr_stb && (ptr_reg == rcc_pkg::RCC_REG_OUT_CFG);
  wire clock_interrupt_flag_set = igoe_reg && |(irq_rise & mask_reg[rcc_pkg::RCC_NUM_IRQ-1:0]);
  wire clock_interrupt_flag_clr = wr_ctl && !rx_byte[rcc_pkg::RCC_CLOCK_INTERRUPT_FLAG_BIT];
  // a new event in the clearing cycle wins over the clear
  assign clock_interrupt_flag_next = clock_interrupt_flag_set | (clock_interrupt_flag_reg & ~clock_interrupt_flag_clr);

  // read mux; unmapped addresses read as zero
  assign rd_data =
    (ptr_reg == rcc_pkg::RCC_REG_INT_CTRL) ? {clock_interrupt_flag_reg, 6'h00, igoe_reg} :
    (ptr_reg == rcc_pkg::RCC_REG_INT_MASK) ? mask_reg :
    (ptr_reg == rcc_pkg::RCC_REG_OUT_CFG) ? cfg_reg : rcc_pkg::RCC_RD_UNMAPPED;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      igoe_reg <= rcc_pkg::RCC_INT_CTRL_RST[rcc_pkg::RCC_IGOE_BIT];
      clock_interrupt_flag_reg <= rcc_pkg::RCC_INT_CTRL_RST[rcc_pkg::RCC_CLOCK_INTERRUPT_FLAG_BIT];
      mask_reg <= rcc_pkg::RCC_INT_MASK_RST;
      cfg_reg <= rcc_pkg::RCC_OUT_CFG_RST;
      irq_d <= '0;
      int_drv_reg <= 1'b0;
    end else begin
      if (wr_ctl) igoe_reg <= rx_byte[rcc_pkg::RCC_IGOE_BIT];
      if (wr_mask) mask_reg <= rx_byte;
      if (wr_cfg) cfg_reg <= rx_byte;
      clock_interrupt_flag_reg <= clock_interrupt_flag_next;
      irq_d <= irq_vec;
      int_drv_reg <= |irq_vec;
    end
  end

  assign int_out = 1'b0;
  assign int_oe_n = ~int_drv_reg;

  // ----------------------------------------------------------------
  // crossing into the oscillator domain
  // ----------------------------------------------------------------
  // config word goes by toggle handshake: hold_reg is frozen until acked
  logic [4:0] hold_reg;
  logic req_reg, ack_m, ack_s, ack_tgl_reg;
  wire [4:0] cfg_word = {cfg_reg[rcc_pkg::RCC_SYNC_BIT], cfg_reg[rcc_pkg::RCC_NOE_BIT],
    cfg_reg[rcc_pkg::RCC_FD_MSB:rcc_pkg::RCC_FD_LSB]};
  wire hs_idle = (ack_s == req_reg);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hold_reg <= {1'b0, rcc_pkg::RCC_OUT_CFG_RST[rcc_pkg::RCC_NOE_BIT], rcc_pkg::RCC_FD_32K};
      {req_reg, ack_m, ack_s} <= 3'h0;
    end else begin
      {ack_m, ack_s} <= {ack_tgl_reg, ack_m};
      if (hs_idle && (hold_reg != cfg_word)) begin
        hold_reg <= cfg_word;
        req_reg <= ~req_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // oscillator domain: divider, enable and pin
  // ----------------------------------------------------------------
  logic orst_m, orst_s, req_m, req_s, clock_interrupt_flag_m, clock_interrupt_flag_s, obat_m, obat_s, tmr_m, tmr_s;
  logic [15:0] div_reg;
  logic [4:0] ocfg_reg;
  logic en_reg, en_next, out_reg;

  function automatic logic [3:0] rcc_tap(input logic [2:0] fd);
    rcc_tap = (fd == rcc_pkg::RCC_FD_8K) ? rcc_pkg::RCC_TAP_8K :
      (fd == rcc_pkg::RCC_FD_1K) ? rcc_pkg::RCC_TAP_1K :
      (fd == rcc_pkg::RCC_FD_64) ? rcc_pkg::RCC_TAP_64 :
      (fd == rcc_pkg::RCC_FD_32) ? rcc_pkg::RCC_TAP_32 :
      (fd == rcc_pkg::RCC_FD_1) ? rcc_pkg::RCC_TAP_1 : rcc_pkg::RCC_TAP_32K;
  endfunction : rcc_tap

  wire [2:0] ofd = ocfg_reg[2:0];
  wire onoe = ocfg_reg[3];
  wire osync = ocfg_reg[4];
  wire is_timer = (ofd == rcc_pkg::RCC_FD_TIMER);
  wire wave = is_timer ? tmr_s : div_reg[rcc_tap(ofd)];
  wire en_want = onoe | clock_interrupt_flag_s;
  wire sync_act = osync & ~is_timer;
  // with sync active, enable moves only in a low phase, so no runt pulse reaches the pin
  assign en_next = (!sync_act || !wave) ? en_want : en_reg;
  wire out_next = en_next & wave & ~obat_s & (ofd != rcc_pkg::RCC_FD_OFF);

  // reset reaches this domain through its own synchroniser
  always_ff @(posedge osc2x_clk) begin
    {orst_m, orst_s} <= {resetn, orst_m};
  end

  always_ff @(posedge osc2x_clk) begin
    if (!orst_s) begin
      {req_m, req_s, ack_tgl_reg} <= 3'h0;
      {clock_interrupt_flag_m, clock_interrupt_flag_s, obat_m, obat_s, tmr_m, tmr_s} <= 6'h00;
      ocfg_reg <= {1'b0, rcc_pkg::RCC_OUT_CFG_RST[rcc_pkg::RCC_NOE_BIT], rcc_pkg::RCC_FD_32K};
      div_reg <= 16'h0000;
      {en_reg, out_reg} <= 2'h0;
    end else begin
      {req_m, req_s} <= {req_reg, req_m};
      {clock_interrupt_flag_m, clock_interrupt_flag_s} <= {clock_interrupt_flag_reg, clock_interrupt_flag_m};
      {obat_m, obat_s} <= {battery_supply_state, obat_m};
      {tmr_m, tmr_s} <= {timer_irq, tmr_m};
      if (req_s != ack_tgl_reg) begin
        ocfg_reg <= hold_reg;
        ack_tgl_reg <= req_s;
      end
      div_reg <= 16'(div_reg + 16'h0001);
      en_reg <= en_next;
      out_reg <= out_next;
    end
  end

  assign square_wave_output_pin = out_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_clear_write;
    clock_interrupt_flag_reg && wr_ctl && !rx_byte[rcc_pkg::RCC_CLOCK_INTERRUPT_FLAG_BIT];
  endsequence
  sequence s_no_event;
    !clock_interrupt_flag_set;
  endsequence

  a_ptr_step: assert property (wr_stb |=> ptr_reg == 8'($past(ptr_reg) + 8'h1))
    else $error("pointer did not step after written byte");
  a_ptr_read: assert property (rd_load |=> ptr_reg == 8'($past(ptr_reg) + 8'h1))
    else $error("pointer did not step after read byte");
  a_flag_start: assert property (clock_interrupt_flag_set |=> clock_interrupt_flag_reg)
    else $error("masked interrupt did not set clock flag");
  a_gate_off: assert property (!igoe_reg && !clock_interrupt_flag_reg |=> !clock_interrupt_flag_reg)
    else $error("clock flag set with gated enable off");
  a_flag_clear: assert property (s_clear_write and s_no_event |=> !clock_interrupt_flag_reg)
    else $error("clock flag not cleared by write");
  a_backup_bus: assert property (bat_s |=> st_reg == rcc_pkg::RCC_ST_IDLE && sda_oe_n)
    else $error("bus active on backup supply");
  a_int_pin: assert property (|irq_vec |=> !int_oe_n)
    else $error("interrupt pin not pulled low");
  a_fd_off: assert property (@(posedge osc2x_clk) disable iff (!orst_s)
    ofd == rcc_pkg::RCC_FD_OFF |=> !square_wave_output_pin)
    else $error("clock pin high with frequency code off");
  a_backup_low: assert property (@(posedge osc2x_clk) disable iff (!orst_s)
    obat_s |=> !square_wave_output_pin)
    else $error("clock pin high on backup supply");
  a_enable_low: assert property (@(posedge osc2x_clk) disable iff (!orst_s)
    !en_want && !sync_act ##1 !en_want |=> !square_wave_output_pin)
    else $error("clock pin high while disabled");
  a_sync_glitch: assert property (@(posedge osc2x_clk) disable iff (!orst_s)
    $past(sync_act) && $changed(en_reg) |-> !$past(wave))
    else $error("synchronised enable changed in high phase");
endmodule : rcc_clock_output
`default_nettype wire

// file: verif/rcc_i2c_host.sv
// host controller model driving the two-wire register bus
`timescale 1ns/10ps
`default_nettype none
module rcc_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // arbitrary bus address
  parameter int QTR = 6
) (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // idle bus: both lines left to the pull-ups
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // each phase lasts QTR core cycles, above the 4 the slave needs
  task automatic tick();
    repeat (QTR) @(posedge core_clk);
  endtask : tick
  // start or repeated start, entered from idle or with scl low
  task automatic start_bit();
    sda_pull <= 1'b0;
    tick();
    scl <= 1'b1;
    tick();
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b0;
    tick();
  endtask : start_bit
  task automatic stop_bit();
    sda_pull <= 1'b1;
    tick();
    scl <= 1'b1;
    tick();
    sda_pull <= 1'b0;
    tick();
  endtask : stop_bit
  // data held over the whole high phase, sampled as scl falls
  task automatic bit_io(input logic tx, output logic rx);
    sda_pull <= ~tx;
    tick();
    scl <= 1'b1;
    tick();
    rx = sda;
    scl <= 1'b0;
    tick();
  endtask : bit_io
  // msb first, then the acknowledge slot
  task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                         output logic ack_rx);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_tx, ack_rx);
  endtask : byte_io
  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] data, output logic nack);
    logic [7:0] rx;
    logic a0, a1, a2;
    start_bit();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a0);
    byte_io(ptr, 1'b1, rx, a1);
    byte_io(data, 1'b1, rx, a2);
    stop_bit();
    nack = a0 | a1 | a2;
  endtask : reg_wr
  // pointer write, repeated start, then n bytes; the last one refused
  task automatic reg_rd(input logic [7:0] ptr, input int n, output logic [23:0] d);
    logic [7:0] rx;
    logic a;
    d = 24'h0;
    start_bit();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, rx, a);
    byte_io(ptr, 1'b1, rx, a);
    start_bit();
    byte_io({DEV_ADDR, 1'b1}, 1'b1, rx, a);
    for (int k = 0; k < n; k++) begin
      byte_io(8'hff, k == n - 1, rx, a);
      d = {d[15:0], rx};
    end
    stop_bit();
  endtask : reg_rd
endmodule : rcc_i2c_host
`default_nettype wire

// file: verif/rtc_clock_output_control_test.sv
// self-checking bench for the clock output control block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module rtc_clock_output_control_test;
  logic core_clk = 1'b0;
  logic osc2x_clk = 1'b0;
  logic resetn = 1'b0;
  logic batt = 1'b0;
  logic saw_drive = 1'b0;
  logic [5:0] src = 6'h00; // timer, update, alarm, event, switchover, power-on
  logic sda_out, sda_oe_n, int_out, int_oe_n, sq, scl, host_pull, nack;
  logic [23:0] d;
  int miscompares = 0;
  int total_checks = 0;
  wire logic sda;
  // ----------------------------------------------------------------
  // clocks, wiring and instances
  // ----------------------------------------------------------------
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // oscillator phase kept unrelated to the core clock
  initial begin
    #3.3;
    forever #7.5 osc2x_clk = ~osc2x_clk;
  end
  // open-drain data line with pull-up: low if either party pulls
  assign sda = ~host_pull & sda_oe_n;
  rcc_clock_output #(.DEV_ADDR(7'h2a)) uut (
    .core_clk(core_clk), .resetn(resetn), .osc2x_clk(osc2x_clk), .scl_pin(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .int_out(int_out),
    .int_oe_n(int_oe_n), .square_wave_output_pin(sq), .battery_supply_state(batt),
    .external_event_input(src[3]), .timer_irq(src[0]), .update_irq(src[1]),
    .alarm_irq(src[2]), .switchover_irq(src[4]), .por_irq(src[5]));
  rcc_i2c_host #(.DEV_ADDR(7'h2a)) host (
    .core_clk(core_clk), .sda(sda), .scl(scl), .sda_pull(host_pull));
  // any pull of the data line by the slave on backup supply is a fault
  always @(posedge core_clk) begin
    if (batt && sda_oe_n === 1'b0) saw_drive <= 1'b1;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d, miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  task automatic wait_osc(input int n);
    repeat (n) @(negedge osc2x_clk);
  endtask : wait_osc
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    host.reg_wr(ptr, data, nack);
    `CHK(nack, 1'b0)
  endtask : wr
  // waits out the config crossing, then counts rising edges on the pin
  task automatic chk_wave(input int n, input int exp);
    int c;
    logic prev;
    c = 0;
    wait_osc(16);
    prev = sq;
    repeat (n) begin
      wait_osc(1);
      if (sq === 1'b1 && prev !== 1'b1) c++;
      prev = sq;
    end
    if (exp == 0) `CHK({c, sq}, 33'h0)
    else `CHK(c >= exp - 1 && c <= exp + 1, 1'b1)
  endtask : chk_wave
  // 6 cycles covers the two-stage sync on the event pin
  task automatic pulse(input int k);
    @(posedge core_clk);
    src[k] <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(int_oe_n, 1'b0)
    src[k] <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK(int_oe_n, 1'b1)
  endtask : pulse
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    // both open-drain pins may only ever pull low
    `CHK({sda_out, int_out}, 2'h0)
    host.reg_rd(8'h35, 1, d);
    `CHK(d[7:0], rcc_pkg::RCC_OUT_CFG_RST)
    wr(8'h11, 8'h5a);
    wr(8'h12, 8'hc4);
    host.reg_rd(8'h10, 3, d);
    `CHK(d, {rcc_pkg::RCC_INT_CTRL_RST, rcc_pkg::RCC_RD_UNMAPPED, 8'hc4})
    $display("test regs done");
  endtask : t_regs
  task automatic t_freq();
    int sh [5] = '{1, 3, 6, 10, 11};
    // 1 hz is still in its first low half second here, so the pin must stay low
    wr(8'h35, 8'h85);
    chk_wave(256, 0);
    for (int k = 0; k < 5; k++) begin
      wr(8'h35, 8'h80 | 8'(k));
      chk_wave(4096, 4096 >> sh[k]);
    end
    wr(8'h35, 8'h87);
    chk_wave(256, 0);
    wr(8'h35, 8'h00);
    chk_wave(256, 0);
    wr(8'h35, 8'hc2);
    chk_wave(1024, 16);
    wr(8'h35, 8'h42);
    chk_wave(256, 0);
    wr(8'h35, 8'hc6);
    src[0] <= 1'b1;
    wait_osc(12);
    `CHK(sq, 1'b1)
    @(posedge core_clk);
    src[0] <= 1'b0;
    wait_osc(12);
    `CHK(sq, 1'b0)
    $display("test freq done");
  endtask : t_freq
  task automatic t_gated();
    wr(8'h12, 8'h0c);
    wr(8'h35, 8'h00);
    wr(8'h10, 8'h01);
    pulse(2);
    host.reg_rd(8'h10, 1, d);
    `CHK(d[7:0], 8'h81)
    chk_wave(256, 128);
    wr(8'h35, 8'h80);
    chk_wave(256, 128);
    wr(8'h35, 8'h00);
    wr(8'h10, 8'h01);
    chk_wave(256, 0);
    wr(8'h10, 8'h00);
    for (int k = 0; k < 6; k++) pulse(k);
    host.reg_rd(8'h10, 1, d);
    `CHK(d[7:0], 8'h00)
    chk_wave(256, 0);
    wr(8'h10, 8'h01);
    $display("test gated done");
  endtask : t_gated
  task automatic t_backup();
    wr(8'h35, 8'h80);
    @(posedge core_clk);
    batt <= 1'b1;
    chk_wave(256, 0);
    pulse(3);
    host.reg_wr(8'h35, 8'h07, nack);
    `CHK(nack, 1'b1)
    `CHK(saw_drive, 1'b0)
    @(posedge core_clk);
    batt <= 1'b0;
    repeat (8) @(posedge core_clk);
    host.reg_rd(8'h35, 1, d);
    `CHK(d[7:0], 8'h80)
    host.reg_rd(8'h10, 1, d);
    `CHK(d[7:0], 8'h81)
    $display("test backup done");
  endtask : t_backup
  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_regs();
    t_freq();
    t_gated();
    t_backup();
    end_sim();
  end
  // the tests need about 490 us; a hang is cut at 750 us, about 94k core cycles
  initial begin
    #750000;
    miscompares++;
    $display("watchdog expired");
    end_sim();
  end
endmodule : rtc_clock_output_control_test
`default_nettype wire
